// ==== hdl/ssio_top.sv ====
// synchronous serial port: baud generator, 16-bit tx and rx channels, avalon-mm registers
// assumes CORE_CLK at 20 MHz, internal serial clock enable pulse from the clock unit
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
module ssio_top (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic INTERNAL_SERIAL_CLOCK_TICK,
  input wire logic [ssio_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic TX_CLOCK_PIN_IN,
  output logic TX_CLOCK_PIN_OUT,
  output logic TX_CLOCK_PIN_OE_B,
  output logic TX_DATA_PIN_OUT,
  output logic TX_DATA_PIN_OE_B,
  input wire logic RX_CLOCK_PIN_IN,
  output logic RX_CLOCK_PIN_OUT,
  output logic RX_CLOCK_PIN_OE_B,
  input wire logic RX_DATA_PIN,
  output logic SERIAL_IRQ_REQUEST,
  output logic TX_DMA_REQUEST,
  output logic RX_DMA_REQUEST
);
  localparam int WW = ssio_pkg::WORD_W;
  localparam int RW = ssio_pkg::RELOAD_W;
  localparam int PW = ssio_pkg::PRESCALE_W;

  logic [WW-1:0] tx_holding_buffer_reg;
  logic [WW-1:0] rx_holding_buffer_reg;
  logic [7:0] baud_control_reg;
  logic [7:0] serial_control_one_reg;
  logic [7:0] serial_control_two_reg;
  logic [PW-1:0] prescale_value_reg;
  logic [7:0] serial_clock_config_reg;
  logic [7:0] pin_function_select_reg;
  logic tx_empty_flag_reg;
  logic tx_underflow_flag_reg;
  logic rx_full_flag_reg;
  logic rx_overflow_flag_reg;
  logic ack_reg;
  logic bus_req;
  logic wr_hit;
  logic rd_hit;
  logic [15:0] index;
  logic [PW:0] pre_count;
  logic ps_tick;
  logic gen_in_tick;
  logic [RW-1:0] gen_count;
  logic gen_half;
  logic gen_clk_reg;
  logic gen_rise;
  logic gen_fall;
  logic txp_level;
  logic txp_rise;
  logic txp_fall;
  logic rxp_level;
  logic rxp_rise;
  logic rxp_fall;
  logic tx_shift_edge;
  logic rx_sample_edge;
  logic [WW-1:0] tx_shift_reg;
  logic [4:0] tx_bits_reg;
  logic tx_active_reg;
  logic [WW-1:0] rx_shift_reg;
  logic [4:0] rx_bits_reg;
  logic rx_active_reg;
  logic tx_load;
  logic rx_done;
  logic tx_irq;
  logic rx_irq;

  // ----------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------
  // one wait cycle per access; byte address is four times the index
  assign bus_req = (AVS_READ || AVS_WRITE) && !ack_reg;
  assign index = AVS_ADDRESS[ssio_pkg::ADDR_W-1:2];
  assign wr_hit = AVS_WRITE && ack_reg && AVS_BYTEENABLE[0];
  assign rd_hit = AVS_READ && ack_reg;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end
  always_comb begin
    AVS_WAITREQUEST = !ack_reg;
  end

  // register writes; flags are handled separately
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_holding_buffer_reg <= ssio_pkg::WORD_RESET;
      baud_control_reg <= ssio_pkg::BYTE_RESET;
      serial_control_one_reg <= ssio_pkg::CONTROL_ONE_RESET;
      serial_control_two_reg <= ssio_pkg::BYTE_RESET;
      prescale_value_reg <= '0;
      serial_clock_config_reg <= ssio_pkg::BYTE_RESET;
      pin_function_select_reg <= ssio_pkg::BYTE_RESET;
    end else if (wr_hit) begin
      unique case (index)
        ssio_pkg::IDX_TX_HOLDING_BUFFER: tx_holding_buffer_reg <= AVS_WRITEDATA[WW-1:0];
        ssio_pkg::IDX_BAUD_CONTROL: baud_control_reg <= AVS_WRITEDATA[7:0];
        ssio_pkg::IDX_SERIAL_CONTROL_ONE: serial_control_one_reg <= AVS_WRITEDATA[7:0];
        ssio_pkg::IDX_SERIAL_CONTROL_TWO: serial_control_two_reg <= AVS_WRITEDATA[7:0];
        ssio_pkg::IDX_PRESCALE_DIVIDER: prescale_value_reg <= AVS_WRITEDATA[PW-1:0];
        ssio_pkg::IDX_SERIAL_CLOCK_CONFIG: serial_clock_config_reg <= AVS_WRITEDATA[7:0];
        ssio_pkg::IDX_PIN_FUNCTION_SELECT: pin_function_select_reg <= AVS_WRITEDATA[7:0];
        default: ;
      endcase
    end
  end

  // read data; write-only registers and unmapped addresses read zero
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      AVS_READDATA <= ssio_pkg::UNMAPPED_READ;
    end else if (AVS_READ && !ack_reg) begin
      unique case (index)
        ssio_pkg::IDX_RX_HOLDING_BUFFER: AVS_READDATA <= {16'h0000, rx_holding_buffer_reg};
        ssio_pkg::IDX_SERIAL_CONTROL_ONE: AVS_READDATA <= {24'h000000, tx_underflow_flag_reg,
          tx_empty_flag_reg, serial_control_one_reg[5:4], rx_overflow_flag_reg,
          rx_full_flag_reg, serial_control_one_reg[1:0]};
        ssio_pkg::IDX_SERIAL_CONTROL_TWO: AVS_READDATA <= {24'h000000, serial_control_two_reg};
        ssio_pkg::IDX_BAUD_COUNT_STATUS: AVS_READDATA <= {24'h000000,
          baud_control_reg[ssio_pkg::GEN_ENABLE_BIT], gen_count};
        ssio_pkg::IDX_SERIAL_CLOCK_CONFIG: AVS_READDATA <= {24'h000000, serial_clock_config_reg};
        ssio_pkg::IDX_PIN_FUNCTION_SELECT: AVS_READDATA <= {24'h000000, pin_function_select_reg};
        default: AVS_READDATA <= ssio_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // clock generation
  // ----------------------------------------------------------------
  // value plus two; a spare bit keeps the top setting from wrapping
  ssio_divider #(.W(PW + 1)) u_prescale (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .run(1'b1),
    .in_tick(1'b1),
    .reload((PW + 1)'({1'b0, prescale_value_reg} + 1'b1)),
    .count(pre_count),
    .out_tick(ps_tick)
  );

  assign gen_in_tick = serial_clock_config_reg[ssio_pkg::GEN_SOURCE_BIT] ? INTERNAL_SERIAL_CLOCK_TICK : ps_tick;

  ssio_divider #(.W(RW)) u_baud (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .run(baud_control_reg[ssio_pkg::GEN_ENABLE_BIT]),
    .in_tick(gen_in_tick),
    .reload(baud_control_reg[RW-1:0]),
    .count(gen_count),
    .out_tick(gen_half)
  );

  // toggling every reload+1 ticks gives input over 2bv+2
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      gen_clk_reg <= 1'b1;
    end else if (!baud_control_reg[ssio_pkg::GEN_ENABLE_BIT]) begin
      gen_clk_reg <= 1'b1;
    end else if (gen_half) begin
      gen_clk_reg <= !gen_clk_reg;
    end
  end
  assign gen_fall = gen_half && gen_clk_reg;
  assign gen_rise = gen_half && !gen_clk_reg;

  // slave clock pins come from outside the core clock
  ssio_edge_sync u_txclk (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .pin(TX_CLOCK_PIN_IN),
    .level(txp_level),
    .rise(txp_rise),
    .fall(txp_fall)
  );
  ssio_edge_sync u_rxclk (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .pin(RX_CLOCK_PIN_IN),
    .level(rxp_level),
    .rise(rxp_rise),
    .fall(rxp_fall)
  );

  // tx shifts on falling edge of generator or pin
  assign tx_shift_edge = serial_control_two_reg[ssio_pkg::TX_MASTER_BIT] ? gen_fall : txp_fall;
  // rx samples on rising edge of generator or pin
  assign rx_sample_edge = serial_control_two_reg[ssio_pkg::RX_MASTER_BIT] ? gen_rise : rxp_rise;

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  // load holding word, shift msb first
  // reload old word on underflow
  // disabling finishes the current word before stopping
  assign tx_load = tx_shift_edge && serial_control_one_reg[ssio_pkg::TX_ON_BIT] &&
    (!tx_active_reg || tx_bits_reg == 5'h01);
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_shift_reg <= ssio_pkg::WORD_RESET;
      tx_bits_reg <= 5'h00;
      tx_active_reg <= 1'b0;
    end else if (tx_load) begin
      tx_shift_reg <= tx_holding_buffer_reg;
      tx_bits_reg <= 5'h10;
      tx_active_reg <= 1'b1;
    end else if (tx_shift_edge && tx_active_reg) begin
      tx_shift_reg <= {tx_shift_reg[WW-2:0], 1'b0};
      tx_bits_reg <= tx_bits_reg - 5'h01;
      tx_active_reg <= (tx_bits_reg != 5'h01);
    end
  end

  // empty set on load, cleared by buffer write; set wins
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_empty_flag_reg <= ssio_pkg::CONTROL_ONE_RESET[ssio_pkg::TX_EMPTY_BIT];
    end else if (tx_load) begin
      tx_empty_flag_reg <= 1'b1;
    end else if (wr_hit && index == ssio_pkg::IDX_TX_HOLDING_BUFFER) begin
      tx_empty_flag_reg <= 1'b0;
    end
  end

  // underflow set on reload of a stale word; only zero clears
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_underflow_flag_reg <= ssio_pkg::CONTROL_ONE_RESET[ssio_pkg::TX_UNDERFLOW_BIT];
    end else if (tx_load && tx_active_reg && tx_empty_flag_reg) begin
      tx_underflow_flag_reg <= 1'b1;
    end else if (wr_hit && index == ssio_pkg::IDX_SERIAL_CONTROL_ONE &&
                 !AVS_WRITEDATA[ssio_pkg::TX_UNDERFLOW_BIT]) begin
      tx_underflow_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  // msb-first capture, word handed over after sixteen bits
  // receiver enable starts a word; a started word always completes
  assign rx_done = rx_sample_edge && rx_active_reg && rx_bits_reg == 5'h0f;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_shift_reg <= ssio_pkg::WORD_RESET;
      rx_bits_reg <= 5'h00;
      rx_active_reg <= 1'b0;
    end else if (rx_sample_edge &&
                 (rx_active_reg || serial_control_one_reg[ssio_pkg::RX_ON_BIT])) begin
      rx_shift_reg <= {rx_shift_reg[WW-2:0], RX_DATA_PIN};
      rx_bits_reg <= rx_done ? 5'h00 : rx_bits_reg + 5'h01;
      rx_active_reg <= !rx_done;
    end
  end

  // transfer always overwrites the holding buffer
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_holding_buffer_reg <= ssio_pkg::WORD_RESET;
    end else if (rx_done) begin
      rx_holding_buffer_reg <= {rx_shift_reg[WW-2:0], RX_DATA_PIN};
    end
  end

  // read of buffer clears; set wins
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_full_flag_reg <= 1'b0;
    end else if (rx_done) begin
      rx_full_flag_reg <= 1'b1;
    end else if (rd_hit && index == ssio_pkg::IDX_RX_HOLDING_BUFFER) begin
      rx_full_flag_reg <= 1'b0;
    end
  end

  // overflow when full word lands on unread buffer
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_overflow_flag_reg <= 1'b0;
    end else if (rx_done && rx_full_flag_reg) begin
      rx_overflow_flag_reg <= 1'b1;
    end else if (wr_hit && index == ssio_pkg::IDX_SERIAL_CONTROL_ONE &&
                 !AVS_WRITEDATA[ssio_pkg::RX_OVERFLOW_BIT]) begin
      rx_overflow_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pins and requests
  // ----------------------------------------------------------------
  // tx empty gated by its enable
  assign tx_irq = tx_empty_flag_reg && serial_control_one_reg[ssio_pkg::TX_IRQ_EN_BIT];
  assign rx_irq = rx_full_flag_reg && serial_control_one_reg[ssio_pkg::RX_IRQ_EN_BIT];
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      SERIAL_IRQ_REQUEST <= 1'b0;
      TX_DMA_REQUEST <= 1'b0;
      RX_DMA_REQUEST <= 1'b0;
    end else begin
      SERIAL_IRQ_REQUEST <= tx_irq || rx_irq;
      TX_DMA_REQUEST <= tx_irq;
      RX_DMA_REQUEST <= rx_irq;
    end
  end

  // pin ownership; idle pins float to external pull-ups
  // master tx drives its clock pin while enabled or running
  // master rx drives its clock pin, when selected by the pin function bit, while enabled or running
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      TX_CLOCK_PIN_OUT <= 1'b1;
      TX_CLOCK_PIN_OE_B <= 1'b1;
      TX_DATA_PIN_OUT <= 1'b1;
      TX_DATA_PIN_OE_B <= 1'b1;
      RX_CLOCK_PIN_OUT <= 1'b1;
      RX_CLOCK_PIN_OE_B <= 1'b1;
    end else begin
      TX_CLOCK_PIN_OUT <= gen_clk_reg;
      TX_CLOCK_PIN_OE_B <= !(serial_control_two_reg[ssio_pkg::TX_MASTER_BIT] &&
        (tx_active_reg || serial_control_one_reg[ssio_pkg::TX_ON_BIT]));
      TX_DATA_PIN_OUT <= tx_active_reg ? tx_shift_reg[WW-1] : tx_holding_buffer_reg[WW-1];
      TX_DATA_PIN_OE_B <= !(pin_function_select_reg[ssio_pkg::TX_PIN_SEL_BIT] &&
        (tx_active_reg || serial_control_one_reg[ssio_pkg::TX_ON_BIT]));
      RX_CLOCK_PIN_OUT <= gen_clk_reg;
      RX_CLOCK_PIN_OE_B <= !(pin_function_select_reg[ssio_pkg::RX_CLK_PIN_SEL_BIT] &&
        serial_control_two_reg[ssio_pkg::RX_MASTER_BIT] &&
        (rx_active_reg || serial_control_one_reg[ssio_pkg::RX_ON_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_gen_stop_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    !baud_control_reg[ssio_pkg::GEN_ENABLE_BIT] |=> gen_count == '0)
    else $error("generator count not zero while stopped");
  a_tx_empty_load: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    tx_load |=> tx_empty_flag_reg)
    else $error("tx empty not set after load");
  a_tx_under_keep: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    tx_underflow_flag_reg && !(wr_hit && index == ssio_pkg::IDX_SERIAL_CONTROL_ONE)
    |=> tx_underflow_flag_reg)
    else $error("underflow flag dropped without write");
  a_rx_full_set: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    rx_done |=> rx_full_flag_reg)
    else $error("rx full not set after transfer");
  a_rx_over_set: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    rx_done && rx_full_flag_reg |=> rx_overflow_flag_reg)
    else $error("overflow not flagged");
  a_irq_combine: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    ##1 SERIAL_IRQ_REQUEST == ($past(tx_irq) || $past(rx_irq)))
    else $error("interrupt line mismatch");
  a_tx_irq_gate: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    !serial_control_one_reg[ssio_pkg::TX_IRQ_EN_BIT] |=> !TX_DMA_REQUEST)
    else $error("tx request leaked while gated");
  a_rx_read_clr: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    rd_hit && index == ssio_pkg::IDX_RX_HOLDING_BUFFER && !rx_done |=> !rx_full_flag_reg)
    else $error("rx full not cleared by read");
  a_bus_answer: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    bus_req |=> !AVS_WAITREQUEST)
    else $error("bus not answered in one cycle");
  c_tx_load: cover property (@(posedge CORE_CLK) disable iff (!RST_B) tx_load);
  c_rx_done: cover property (@(posedge CORE_CLK) disable iff (!RST_B) rx_done);
  c_underflow: cover property (@(posedge CORE_CLK) disable iff (!RST_B)
    $rose(tx_underflow_flag_reg));
endmodule

// ==== hdl/ssio_pkg.sv ====
// package: register map, field positions, field widths and reset values of the serial port
// assumes a 32-bit avalon-mm slave with word addresses derived from printed offsets
package ssio_pkg;
  // ----------------------------------------------------------------
  // register indices (printed offsets are not word aligned)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_TX_HOLDING_BUFFER = 16'hf480;
  localparam logic [15:0] IDX_RX_HOLDING_BUFFER = 16'hf482;
  localparam logic [15:0] IDX_BAUD_CONTROL = 16'hf484;
  localparam logic [15:0] IDX_SERIAL_CONTROL_ONE = 16'hf486;
  localparam logic [15:0] IDX_SERIAL_CONTROL_TWO = 16'hf488;
  localparam logic [15:0] IDX_BAUD_COUNT_STATUS = 16'hf48a;
  localparam logic [15:0] IDX_PRESCALE_DIVIDER = 16'hf804;
  localparam logic [15:0] IDX_SERIAL_CLOCK_CONFIG = 16'hf836;
  localparam logic [15:0] IDX_PIN_FUNCTION_SELECT = 16'hf826;
  localparam int ADDR_W = 18;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GEN_SOURCE_BIT = 2;
  localparam int GEN_ENABLE_BIT = 7;
  localparam int TX_UNDERFLOW_BIT = 7;
  localparam int TX_EMPTY_BIT = 6;
  localparam int TX_IRQ_EN_BIT = 5;
  localparam int TX_ON_BIT = 4;
  localparam int RX_OVERFLOW_BIT = 3;
  localparam int RX_FULL_BIT = 2;
  localparam int RX_IRQ_EN_BIT = 1;
  localparam int RX_ON_BIT = 0;
  localparam int TX_MASTER_BIT = 1;
  localparam int RX_MASTER_BIT = 0;
  localparam int TX_PIN_SEL_BIT = 0;
  localparam int RX_CLK_PIN_SEL_BIT = 1;
  localparam int PRESCALE_W = 9;
  localparam int RELOAD_W = 7;
  localparam int WORD_W = 16;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_ONE_RESET = 8'hc0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// ==== hdl/ssio_divider.sv ====
// divide-by-n tick generator: one-cycle tick every (reload+1) enabled input ticks
// assumes in_tick is a single-cycle pulse on clk
`timescale 1ns/1ps
module ssio_divider #(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic in_tick,
  input wire logic [W-1:0] reload,
  output logic [W-1:0] count,
  output logic out_tick
);
  // ----------------------------------------------------------------
  // down counter
  // ----------------------------------------------------------------
  // stopped counter holds zero so a restart reloads at once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else if (!run) begin
      count <= '0;
    end else if (in_tick) begin
      if (count == '0) begin
        count <= reload;
      end else begin
        count <= count - 1'b1;
      end
    end
  end
  assign out_tick = run && in_tick && (count == '0);
endmodule

// ==== hdl/ssio_edge_sync.sv ====
// three-flop synchroniser for a pin with rising and falling event pulses
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
module ssio_edge_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  // ----------------------------------------------------------------
  // sync chain
  // ----------------------------------------------------------------
  // a change counts once the second and third flops agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      level <= 1'b1;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level <= s3_reg;
      end
    end
  end
  assign rise = (s2_reg == s3_reg) && s3_reg && !level;
  assign fall = (s2_reg == s3_reg) && !s3_reg && level;
endmodule

// ==== tb/ssio_peer.sv ====
// far-side serial device: captures tx data, feeds rx data msb first
// assumes pin levels already resolved with pull-ups by the bench
`timescale 1ns/1ps
module ssio_peer (
  input wire logic clk,
  input wire logic tx_clk,
  input wire logic tx_dat,
  input wire logic rx_clk,
  input wire logic rx_idle,
  input wire logic [15:0] rx_word,
  output logic rx_dat,
  output logic [15:0] got
);
  logic tc_q = 1'b1;
  logic rc_q = 1'b1;
  logic [3:0] idx = 4'hf;
  // edges seen one core cycle late, data is stable around them anyway
  always @(posedge clk) begin
    tc_q <= tx_clk;
    rc_q <= rx_clk;
    if (tx_clk && !tc_q)
      got <= {got[14:0], tx_dat};
    // next bit once the receiver has sampled on the rising clock
    if (rx_idle)
      idx <= 4'hf;
    else if (rx_clk && !rc_q)
      idx <= idx - 4'h1;
  end
  // pull-up holds the line high outside frames
  assign rx_dat = rx_idle ? 1'b1 : rx_word[idx];
endmodule

// ==== tb/tb.sv ====
// bench: register bus, flags, interrupt lines, master tx and rx words
// assumes ssio_pkg and the peer model are compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
  logic CORE_CLK = 0, RST_B = 0, rd = 0, wr = 0, wq;
  logic [17:0] adr = '0;
  logic [31:0] wd = '0, rdat, rv;
  logic tco, tcb, tdo, tdb, rco, rcb, rxd, irq, tdma, rdma;
  logic [15:0] got;
  int n_mismatch = 0, n_tests = 0, cyc = 0, t0;
  // pull-ups on released pins
  wire tck = tcb ? 1'b1 : tco;
  wire rck = rcb ? 1'b1 : rco;
  wire txd = tdb ? 1'b1 : tdo;
  ssio_top u_ssio_top (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .INTERNAL_SERIAL_CLOCK_TICK(1'b1),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq),
    .TX_CLOCK_PIN_IN(tck), .TX_CLOCK_PIN_OUT(tco), .TX_CLOCK_PIN_OE_B(tcb),
    .TX_DATA_PIN_OUT(tdo), .TX_DATA_PIN_OE_B(tdb), .RX_CLOCK_PIN_IN(rck),
    .RX_CLOCK_PIN_OUT(rco), .RX_CLOCK_PIN_OE_B(rcb), .RX_DATA_PIN(rxd),
    .SERIAL_IRQ_REQUEST(irq), .TX_DMA_REQUEST(tdma), .RX_DMA_REQUEST(rdma));
  ssio_peer u_ssio_peer (.clk(CORE_CLK), .tx_clk(tck), .tx_dat(txd), .rx_clk(rck),
    .rx_idle(rcb), .rx_word(16'h9c35), .rx_dat(rxd), .got(got));
  // ------------------------------------------------------------
  // clock, timeout and closing report
  // ------------------------------------------------------------
  initial forever #25 CORE_CLK = ~CORE_CLK;
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ceiling well above the few thousand cycles the scenarios need
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [15:0] i, input logic [15:0] d);
    @(posedge CORE_CLK);
    adr <= {i, 2'b00};
    wd <= {16'h0, d};
    rd <= !w;
    wr <= w;
    do @(posedge CORE_CLK); while (wq !== 1'b0);
    rv = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // poll a control-one bit until it reads one
  task automatic poll(input int b);
    do bus(0, ssio_pkg::IDX_SERIAL_CONTROL_ONE, 0); while (rv[b] !== 1'b1);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    bus(0, ssio_pkg::IDX_SERIAL_CONTROL_ONE, 0);
    `CHK("con1", 8'hc0, rv[7:0])
    bus(0, ssio_pkg::IDX_BAUD_COUNT_STATUS, 0);
    `CHK("status", 8'h00, rv[7:0])
    bus(0, ssio_pkg::IDX_RX_HOLDING_BUFFER, 0);
    `CHK("rxbuf", 32'h0, rv)
    bus(0, 16'hf400, 0);
    `CHK("unmapped", 32'h0, rv)
  endtask
  task automatic t_irq();
    bus(1, ssio_pkg::IDX_SERIAL_CONTROL_ONE, 16'ha0);
    repeat (2) @(posedge CORE_CLK);
    `CHK("irq", 1'b1, irq)
    `CHK("txdma", 1'b1, tdma)
    bus(0, ssio_pkg::IDX_SERIAL_CONTROL_ONE, 0);
    `CHK("flag kept", 8'he0, rv[7:0])
    bus(1, ssio_pkg::IDX_SERIAL_CONTROL_ONE, 16'h00);
    repeat (2) @(posedge CORE_CLK);
    `CHK("masked", 1'b0, irq)
    bus(0, ssio_pkg::IDX_SERIAL_CONTROL_ONE, 0);
    `CHK("flag cleared", 8'h40, rv[7:0])
  endtask
  // serial clock source, generator running, both pins owned, both sides master
  task automatic t_gen();
    bus(1, ssio_pkg::IDX_SERIAL_CLOCK_CONFIG, 16'h04);
    bus(1, ssio_pkg::IDX_BAUD_CONTROL, 16'h82);
    bus(0, ssio_pkg::IDX_BAUD_COUNT_STATUS, 0);
    `CHK("running", 1'b1, rv[7] & (rv[6:0] <= 7'h2))
    bus(1, ssio_pkg::IDX_SERIAL_CONTROL_TWO, 16'h03);
    bus(1, ssio_pkg::IDX_PIN_FUNCTION_SELECT, 16'h03);
    bus(0, ssio_pkg::IDX_PIN_FUNCTION_SELECT, 0);
    `CHK("pin select", 8'h03, rv[7:0])
  endtask
  // b = 6: refilled in time, b = 7: left to underflow and resend
  task automatic t_tx(input logic [15:0] w, input int b);
    bus(1, ssio_pkg::IDX_TX_HOLDING_BUFFER, w);
    bus(0, ssio_pkg::IDX_SERIAL_CONTROL_ONE, 0);
    `CHK("empty clr", 1'b0, rv[6])
    bus(1, ssio_pkg::IDX_SERIAL_CONTROL_ONE, 16'h10);
    @(posedge tck);
    t0 = cyc;
    @(posedge tck);
    `CHK("period", 6, cyc - t0)
    poll(b);
    if (b == 6) begin
      // refill well inside sixteen bit times
      w = ~w;
      bus(1, ssio_pkg::IDX_TX_HOLDING_BUFFER, w);
      poll(6);
      `CHK("no underflow", 1'b0, rv[7])
    end
    bus(1, ssio_pkg::IDX_SERIAL_CONTROL_ONE, 16'h80);
    wait (tcb === 1'b1);
    `CHK("tx word", w, got)
  endtask
  task automatic t_rx();
    // park the generator high so the receiver never samples before the pin is driven
    bus(1, ssio_pkg::IDX_BAUD_CONTROL, 16'h00);
    bus(1, ssio_pkg::IDX_SERIAL_CONTROL_ONE, 16'h03);
    bus(1, ssio_pkg::IDX_BAUD_CONTROL, 16'h82);
    poll(2);
    repeat (2) @(posedge CORE_CLK);
    `CHK("rx irq", 1'b1, irq)
    poll(3);
    bus(1, ssio_pkg::IDX_SERIAL_CONTROL_ONE, 16'h08);
    wait (rcb === 1'b1);
    bus(0, ssio_pkg::IDX_RX_HOLDING_BUFFER, 0);
    `CHK("rx word", 16'h9c35, rv[15:0])
    bus(0, ssio_pkg::IDX_SERIAL_CONTROL_ONE, 0);
    `CHK("full clr", 2'b10, rv[3:2])
    bus(1, ssio_pkg::IDX_SERIAL_CONTROL_ONE, 16'h00);
    bus(0, ssio_pkg::IDX_SERIAL_CONTROL_ONE, 0);
    `CHK("ovf clr", 1'b0, rv[3])
  endtask
  // largest prescale setting, reload zero: two prescaled ticks per bit clock
  task automatic t_prescale();
    bus(1, ssio_pkg::IDX_SERIAL_CLOCK_CONFIG, 16'h00);
    bus(1, ssio_pkg::IDX_PRESCALE_DIVIDER, 16'h01ff);
    bus(1, ssio_pkg::IDX_BAUD_CONTROL, 16'h80);
    bus(1, ssio_pkg::IDX_SERIAL_CONTROL_ONE, 16'h01);
    @(posedge rck);
    t0 = cyc;
    @(posedge rck);
    `CHK("prescaled period", 2 * (9'h1ff + 2), cyc - t0)
    bus(1, ssio_pkg::IDX_BAUD_CONTROL, 16'h00);
    bus(0, ssio_pkg::IDX_BAUD_COUNT_STATUS, 0);
    `CHK("stopped", 8'h00, rv[7:0])
  endtask
  initial begin
    repeat (2) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    t_reset();
    t_irq();
    t_gen();
    t_tx(16'ha5c3, 6);
    t_tx(16'h0f0f, 7);
    t_rx();
    t_prescale();
    final_report();
  end
endmodule
